//--- hw/pcm_bus_timing_routing.sv
// pcm bus timing, dpll, codec enables, slot routing and frame counter
// Function
// - codec style 0 drives eight slot selects; style 1 drives shapes and slot count.
// - adjust speed 00..11 gives four..one half-step corrections in the last slot.
// - rate code picks 32, 64 or 128 slots and bit clock; code 11 unused.
// - every slot has separate transmit and receive routing entries.
// - test loop feeds transmitted data back to receive in every slot whose receive code is not ignore.
// - sync-from-pll makes sync output the pll bit clock divided by eight.
// - pll sync source is line receive timing at 0, sync input at 1.
// - otherwise sync output is line timing or a copy of sync input.
// - in manual mode lengthen bit stretches frame at 1, shortens at 0.
// - automatic tracking when manual bit is 0, software steering when 1.
// - manual adjustment yields whenever a sync pulse is available.
// - each shape has sixteen bits, one per half bit clock of the slot.
// - top shape bit holds the level for the rest of the slot.
// - mode one, mode two and shapes share the multi address, chosen by index.
// - transmit codes: off, internal loop, drive pin one, drive pin two.
// - receive codes: ignore, internal loop, pin two, pin one.
// - sixteen-bit frame ring counter; the high byte reads the value latched by the last low-byte read.
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module pcm_bus_timing_routing
   import pcm_timing_pkg::*;
(
   input  wire  logic        mclk,
   input  wire  logic        nrst,
   input  wire  logic [7:0]  address,
   input  wire  logic        read,
   input  wire  logic        write,
   input  wire  logic [31:0] writedata,
   input  wire  logic [3:0]  byteenable,
   output logic [31:0]       readdata,
   output logic              waitrequest,
   input  wire  logic        syncIn,
   input  wire  logic        lineSync,
   output logic              syncOut,
   output logic              pllClockOut,
   output logic              frameSyncPulse,
   output logic [7:0]        slotSelectPin,
   output logic              shapePulseA,
   output logic              shapePulseB,
   output logic [6:0]        slotCountOut,
   input  wire  logic        pinOneIn,
   output logic              pinOneOut,
   output logic              pinOneOeN,
   input  wire  logic        pinTwoIn,
   output logic              pinTwoOut,
   output logic              pinTwoOeN,
   output logic [4:0]        txChannel,
   output logic              txActive,
   input  wire  logic [7:0]  txByte,
   output rxWord_t           rxWord
);
   // ---------------- register bus ----------------
   logic        ackQ, ackD;
   logic [31:0] rdQ, rdD;
   logic [7:0]  slotSelQ, slotSelD;
   logic [7:0]  mode0Q, mode0D, mode1Q, mode1D, mode2Q, mode2D;
   logic [15:0] shapeAQ, shapeAD, shapeBQ, shapeBD;
   logic [7:0]  selRegQ [8];
   logic [7:0]  selRegD [8];
   logic [7:0]  hiLatchQ, hiLatchD;
   logic [15:0] fcntQ, fcntD;
   routeEntry_t routeMem [256];
   logic        wrTake, rdStart;
   logic [3:0]  mIdx;

   assign mIdx        = mode0Q[MODE0_IDX_LSB +: 4];
   assign waitrequest = (read | write) & ~ackQ;
   assign wrTake      = write & ackQ & byteenable[0];
   assign rdStart     = read & ~ackQ;
   assign readdata    = rdQ;

   always_comb begin
      ackD     = (read | write) & ~ackQ;
      rdD      = rdQ;
      slotSelD = slotSelQ;
      mode0D   = mode0Q;
      mode1D   = mode1Q;
      mode2D   = mode2Q;
      shapeAD  = shapeAQ;
      shapeBD  = shapeBQ;
      selRegD  = selRegQ;
      hiLatchD = hiLatchQ;
      if (rdStart) begin
         // write-only and unmapped words read as zero
         rdD = 32'h0000_0000;
         if (address == IDX_FCNT_LOW) begin
            rdD      = {24'h00_0000, fcntQ[7:0]};
            hiLatchD = fcntQ[15:8];
         end else if (address == IDX_FCNT_HIGH) begin
            rdD = {24'h00_0000, hiLatchQ};
         end
      end
      if (wrTake) begin
         unique case (address)
            IDX_SLOT_SEL:  slotSelD = writedata[7:0];
            IDX_MODE_ZERO: mode0D   = writedata[7:0];
            IDX_MULTI: begin
               if (mIdx < 4'h8) begin
                  selRegD[mIdx[2:0]] = writedata[7:0];
               end else if (mIdx == MR_MODE_ONE) begin
                  mode1D = writedata[7:0];
               end else if (mIdx == MR_MODE_TWO) begin
                  mode2D = writedata[7:0];
               end else if (mIdx == MR_SHA_LOW) begin
                  shapeAD[7:0] = writedata[7:0];
               end else if (mIdx == MR_SHA_HIGH) begin
                  shapeAD[15:8] = writedata[7:0];
               end else if (mIdx == MR_SHB_LOW) begin
                  shapeBD[7:0] = writedata[7:0];
               end else if (mIdx == MR_SHB_HIGH) begin
                  shapeBD[15:8] = writedata[7:0];
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ackQ     <= 1'b0;
         rdQ      <= 32'h0000_0000;
         slotSelQ <= MODE_RESET;
         mode0Q   <= MODE_RESET;
         mode1Q   <= MODE_RESET;
         mode2Q   <= MODE_RESET;
         shapeAQ  <= {SHAPE_RESET, SHAPE_RESET};
         shapeBQ  <= {SHAPE_RESET, SHAPE_RESET};
         hiLatchQ <= 8'h00;
         for (int i = 0; i < 8; i++) begin
            selRegQ[i] <= SEL_RESET;
         end
      end else begin
         ackQ     <= ackD;
         rdQ      <= rdD;
         slotSelQ <= slotSelD;
         mode0Q   <= mode0D;
         mode1Q   <= mode1D;
         mode2Q   <= mode2D;
         shapeAQ  <= shapeAD;
         shapeBQ  <= shapeBD;
         hiLatchQ <= hiLatchD;
         selRegQ  <= selRegD;
      end
   end

   // routing table, indexed by slot number and direction; cleared so unused slots stay silent
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < 256; i++) begin
            routeMem[i] <= routeEntry_t'(ROUTE_RESET);
         end
      end else if (wrTake && address == IDX_ROUTING) begin
         routeMem[slotSelQ] <= routeEntry_t'(writedata[7:0]);
      end
   end

   // ---------------- configuration decode ----------------
   logic       codecStyle, testLoop, syncPll, syncSrc, syncOutSrc, lengthen, manual;
   logic [1:0] adjSpeed, rate;
   logic [6:0] slotMax;
   logic [5:0] halfNominal;
   logic [2:0] adjCount;

   assign codecStyle = mode1Q[MD1_CODEC];
   assign adjSpeed   = mode1Q[MD1_ADJ_LSB +: 2];
   assign rate       = mode1Q[MD1_RATE_LSB +: 2];
   assign testLoop   = mode1Q[MD1_LOOP];
   assign syncPll    = mode2Q[MD2_SYNC_PLL];
   assign syncSrc    = mode2Q[MD2_SYNC_SRC];
   assign syncOutSrc = mode2Q[MD2_SYNC_OUT];
   assign lengthen   = mode2Q[MD2_LENGTHEN];
   assign manual     = mode2Q[MD2_MANUAL];
   assign adjCount   = ADJ_MAX - {1'b0, adjSpeed};

   always_comb begin
      // unused code 11 falls back to the slowest rate
      unique case (rate)
         RATE_4M: begin
            slotMax     = SLOTS_4M;
            halfNominal = HALF_4M;
         end
         RATE_8M: begin
            slotMax     = SLOTS_8M;
            halfNominal = HALF_8M;
         end
         default: begin
            slotMax     = SLOTS_2M;
            halfNominal = HALF_2M;
         end
      endcase
   end

   // ---------------- dpll and frame timing ----------------
   logic [5:0] halfCntQ, halfCntD;
   logic [4:0] halfIdxQ, halfIdxD;
   logic [6:0] slotQ, slotD;
   logic       bitClkQ, bitClkD;
   logic [1:0] div8Q, div8D;
   logic       div8OutQ, div8OutD;
   logic [2:0] adjLeftQ, adjLeftD;
   logic       adjPendQ, adjPendD, adjLongQ, adjLongD, adjDirQ, adjDirD;
   logic [1:0] missQ, missD;
   logic       srcPrevQ, srcPrevD;
   logic       halfTick, slotEnd, frameEnd, syncEdge, syncAvail, manualActive, srcLevel;
   logic       frameStart;

   assign srcLevel     = syncSrc ? syncIn : lineSync;
   assign syncEdge     = srcLevel & ~srcPrevQ;
   assign syncAvail    = missQ < SYNC_MISS_LIMIT;
   assign manualActive = manual & ~syncAvail;
   assign halfTick     = (halfCntQ == 6'h00);
   assign slotEnd      = halfTick & (halfIdxQ == 5'h1f);
   assign frameEnd     = slotEnd & (slotQ == slotMax);
   assign frameStart   = frameEnd;

   always_comb begin
      halfCntD = halfCntQ - 6'h01;
      halfIdxD = halfIdxQ;
      slotD    = slotQ;
      bitClkD  = bitClkQ;
      div8D    = div8Q;
      div8OutD = div8OutQ;
      adjLeftD = adjLeftQ;
      adjPendD = adjPendQ;
      adjLongD = adjLongQ;
      adjDirD  = adjDirQ;
      missD    = missQ;
      srcPrevD = srcLevel;
      fcntD    = fcntQ;
      if (halfTick) begin
         halfCntD = halfNominal - 6'h01;
         if (adjLeftQ != 3'h0) begin
            // one system cycle per correction step
            halfCntD = adjDirQ ? halfNominal : halfNominal - 6'h02;
            adjLeftD = adjLeftQ - 3'h1;
         end
         bitClkD  = ~bitClkQ;
         halfIdxD = halfIdxQ + 5'h01;
         if (bitClkQ) begin
            div8D = div8Q + 2'h1;
            if (div8Q == 2'b11) begin
               div8OutD = ~div8OutQ;
            end
         end
         if (slotEnd) begin
            slotD = (slotQ >= slotMax) ? 7'h00 : slotQ + 7'h01;
         end
         // entering the last slot: load the correction budget
         if (slotEnd && slotQ == slotMax - 7'h01) begin
            if (manualActive) begin
               adjLeftD = adjCount;
               adjDirD  = lengthen;
            end else if (adjPendQ) begin
               adjLeftD = adjCount;
               adjDirD  = adjLongQ;
               adjPendD = 1'b0;
            end
         end
      end
      if (frameStart) begin
         fcntD = fcntQ + 16'h0001;
         if (missQ != 2'h3) begin
            missD = missQ + 2'h1;
         end
      end
      if (syncEdge) begin
         // set wins over the clear above
         missD    = 2'h0;
         adjPendD = 1'b1;
         adjLongD = (slotQ < {1'b0, slotMax[6:1]});
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         halfCntQ <= 6'h00;
         halfIdxQ <= 5'h00;
         slotQ    <= 7'h00;
         bitClkQ  <= 1'b0;
         div8Q    <= 2'h0;
         div8OutQ <= 1'b0;
         adjLeftQ <= 3'h0;
         adjPendQ <= 1'b0;
         adjLongQ <= 1'b0;
         adjDirQ  <= 1'b0;
         missQ    <= 2'h3;
         srcPrevQ <= 1'b0;
         fcntQ    <= 16'h0000;
      end else begin
         halfCntQ <= halfCntD;
         halfIdxQ <= halfIdxD;
         slotQ    <= slotD;
         bitClkQ  <= bitClkD;
         div8Q    <= div8D;
         div8OutQ <= div8OutD;
         adjLeftQ <= adjLeftD;
         adjPendQ <= adjPendD;
         adjLongQ <= adjLongD;
         adjDirQ  <= adjDirD;
         missQ    <= missD;
         srcPrevQ <= srcPrevD;
         fcntQ    <= fcntD;
      end
   end

   // ---------------- slot data path and pin outputs ----------------
   routeEntry_t txEnt, rxEnt;
   logic        txBit, rxBit, shapeLvlA, shapeLvlB;
   logic [7:0]  rxShQ, rxShD;
   rxWord_t     rxWordQ, rxWordD;
   logic [7:0]  selPinD;
   logic        shAD, shBD, syncD, fsD, p1D, p1OeD, p2D, p2OeD;
   logic [6:0]  slotCntD;
   logic [6:0]  selPinQ_slot [8];
   logic [7:0]  selPinQ;
   logic        shAQ, shBQ, syncQ, fsQ, p1Q, p1OeQ, p2Q, p2OeQ;
   logic [6:0]  slotCntQ;

   assign txEnt     = routeMem[{slotQ, 1'b0}];
   assign rxEnt     = routeMem[{slotQ, 1'b1}];
   assign txBit     = txByte[3'h7 - halfIdxQ[4:2]];
   assign txChannel = txEnt.chan;
   assign txActive  = (txEnt.code != ROUTE_OFF);
   // beyond sixteen halves the top bit holds the level
   assign shapeLvlA = (halfIdxQ < SHAPE_HALVES) ? shapeAQ[halfIdxQ[3:0]] : shapeAQ[15];
   assign shapeLvlB = (halfIdxQ < SHAPE_HALVES) ? shapeBQ[halfIdxQ[3:0]] : shapeBQ[15];

   always_comb begin
      unique case (rxEnt.code)
         ROUTE_LOOP:  rxBit = txBit;
         ROUTE_PIN_A: rxBit = pinTwoIn;
         ROUTE_PIN_B: rxBit = pinOneIn;
         default:     rxBit = 1'b0;
      endcase
      if (testLoop) begin
         rxBit = txBit;
      end
      rxShD   = rxShQ;
      rxWordD = rxWordQ;
      rxWordD.valid = 1'b0;
      if (halfTick && halfIdxQ[1:0] == 2'b10) begin
         rxShD = {rxShQ[6:0], rxBit};
      end
      if (slotEnd && rxEnt.code != ROUTE_OFF) begin
         rxWordD.valid = 1'b1;
         rxWordD.chan  = rxEnt.chan;
         rxWordD.data  = rxShQ;
      end
      p1D   = txBit;
      p2D   = txBit;
      p1OeD = ~(txEnt.code == ROUTE_PIN_A);
      p2OeD = ~(txEnt.code == ROUTE_PIN_B);
      for (int i = 0; i < 8; i++) begin
         selPinQ_slot[i] = (selRegQ[i][6:0] >= slotMax) ? 7'h00 : selRegQ[i][6:0] + 7'h01;
         selPinD[i] = 1'b0;
         if (!codecStyle && selRegQ[i] != SEL_RESET && slotQ == selPinQ_slot[i]) begin
            selPinD[i] = selRegQ[i][7] ? shapeLvlB : shapeLvlA;
         end
      end
      shAD     = codecStyle & shapeLvlA;
      shBD     = codecStyle & shapeLvlB;
      slotCntD = codecStyle ? slotQ : 7'h00;
      if (syncPll) begin
         syncD = div8OutQ;
      end else begin
         syncD = syncOutSrc ? syncIn : lineSync;
      end
      fsD = (slotQ == 7'h00) & (halfIdxQ < 5'h02);
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rxShQ    <= 8'h00;
         rxWordQ  <= '0;
         selPinQ  <= 8'h00;
         shAQ     <= 1'b0;
         shBQ     <= 1'b0;
         slotCntQ <= 7'h00;
         syncQ    <= 1'b0;
         fsQ      <= 1'b0;
         p1Q      <= 1'b0;
         p2Q      <= 1'b0;
         p1OeQ    <= 1'b1;
         p2OeQ    <= 1'b1;
      end else begin
         rxShQ    <= rxShD;
         rxWordQ  <= rxWordD;
         selPinQ  <= selPinD;
         shAQ     <= shAD;
         shBQ     <= shBD;
         slotCntQ <= slotCntD;
         syncQ    <= syncD;
         fsQ      <= fsD;
         p1Q      <= p1D;
         p2Q      <= p2D;
         p1OeQ    <= p1OeD;
         p2OeQ    <= p2OeD;
      end
   end

   assign rxWord         = rxWordQ;
   assign slotSelectPin  = selPinQ;
   assign shapePulseA    = shAQ;
   assign shapePulseB    = shBQ;
   assign slotCountOut   = slotCntQ;
   assign syncOut        = syncQ;
   assign frameSyncPulse = fsQ;
   assign pllClockOut    = bitClkQ;
   assign pinOneOut      = p1Q;
   assign pinTwoOut      = p2Q;
   assign pinOneOeN      = p1OeQ;
   assign pinTwoOeN      = p2OeQ;

   // ---------------- checks ----------------
   a_wait_one_cycle: assert property (@(posedge mclk) disable iff (!nrst)
      $rose(read) |-> waitrequest ##1 !waitrequest)
      else $error("bus answer not after one wait cycle");
   a_high_capture: assert property (@(posedge mclk) disable iff (!nrst)
      (rdStart && address == IDX_FCNT_LOW) |=> hiLatchQ == $past(fcntQ[15:8]) && rdQ[7:0] == $past(fcntQ[7:0]))
      else $error("high byte not captured with low byte");
   a_frame_count: assert property (@(posedge mclk) disable iff (!nrst)
      frameStart |=> fcntQ == $past(fcntQ) + 16'h0001)
      else $error("frame counter did not step");
   a_slot_range: assert property (@(posedge mclk) disable iff (!nrst)
      $stable(rate) && slotEnd && slotQ == slotMax |=> slotQ == 7'h00)
      else $error("slot counter did not wrap at slot count");
   a_adjust_budget: assert property (@(posedge mclk) disable iff (!nrst)
      (halfTick && slotEnd && slotQ == slotMax - 7'h01 && manualActive) |=> adjLeftQ == $past(adjCount))
      else $error("wrong number of corrections");
   a_manual_dir: assert property (@(posedge mclk) disable iff (!nrst)
      (slotEnd && slotQ == slotMax - 7'h01 && manualActive) |=> adjDirQ == $past(lengthen))
      else $error("manual direction not taken");
   a_sync_copy: assert property (@(posedge mclk) disable iff (!nrst)
      (!syncPll && syncOutSrc) |=> syncOut == $past(syncIn))
      else $error("sync output not a copy of sync input");
   a_shape_tail: assert property (@(posedge mclk) disable iff (!nrst)
      (codecStyle && halfIdxQ >= SHAPE_HALVES) |=> shapePulseA == $past(shapeAQ[15]))
      else $error("shape tail level wrong");
   a_codec_style: assert property (@(posedge mclk) disable iff (!nrst)
      !codecStyle |=> !shapePulseA && !shapePulseB && slotCountOut == 7'h00)
      else $error("shape outputs active in select-pin style");
   a_pin_drive: assert property (@(posedge mclk) disable iff (!nrst)
      (txEnt.code == ROUTE_PIN_A) |=> !pinOneOeN && pinTwoOeN)
      else $error("pin one not driven alone");
   a_rx_emit: assert property (@(posedge mclk) disable iff (!nrst)
      (slotEnd && rxEnt.code == ROUTE_OFF) |=> !rxWord.valid)
      else $error("ignored receive slot produced data");
endmodule
`default_nettype wire

//--- hw/pcm_timing_pkg.sv
// shared constants and types of the pcm bus timing and routing block
package pcm_timing_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_SLOT_SEL   = 8'h10;
   localparam logic [7:0] IDX_MODE_ZERO  = 8'h14;
   localparam logic [7:0] IDX_MULTI      = 8'h15;
   localparam logic [7:0] IDX_FCNT_LOW   = 8'h18;
   localparam logic [7:0] IDX_FCNT_HIGH  = 8'h19;
   localparam logic [7:0] IDX_ROUTING    = 8'hd0;
   // multi-register selector values
   localparam logic [3:0] MR_MODE_ONE    = 4'h9;
   localparam logic [3:0] MR_MODE_TWO    = 4'ha;
   localparam logic [3:0] MR_SHA_LOW     = 4'hc;
   localparam logic [3:0] MR_SHA_HIGH    = 4'hd;
   localparam logic [3:0] MR_SHB_LOW     = 4'he;
   localparam logic [3:0] MR_SHB_HIGH    = 4'hf;
   // field positions
   localparam int MODE0_IDX_LSB  = 4;
   localparam int MD1_CODEC      = 0;
   localparam int MD1_ADJ_LSB    = 2;
   localparam int MD1_RATE_LSB   = 4;
   localparam int MD1_LOOP       = 6;
   localparam int MD2_SYNC_PLL   = 1;
   localparam int MD2_SYNC_SRC   = 2;
   localparam int MD2_SYNC_OUT   = 3;
   localparam int MD2_LENGTHEN   = 6;
   localparam int MD2_MANUAL     = 7;
   // reset values
   localparam logic [7:0] SEL_RESET    = 8'hff;
   localparam logic [7:0] MODE_RESET   = 8'h00;
   localparam logic [7:0] SHAPE_RESET  = 8'h00;
   localparam logic [7:0] ROUTE_RESET  = 8'h00;
   // rates and timing
   localparam logic [1:0] RATE_2M  = 2'b00;
   localparam logic [1:0] RATE_4M  = 2'b01;
   localparam logic [1:0] RATE_8M  = 2'b10;
   localparam logic [6:0] SLOTS_2M = 7'h1f;
   localparam logic [6:0] SLOTS_4M = 7'h3f;
   localparam logic [6:0] SLOTS_8M = 7'h7f;
   localparam longint CLK_HZ       = 250000000;
   localparam longint BITCLK_2M_HZ = 4096000;
   localparam longint BITCLK_4M_HZ = 8192000;
   localparam longint BITCLK_8M_HZ = 16384000;
   localparam logic [5:0] HALF_2M  = 6'(CLK_HZ / (2 * BITCLK_2M_HZ));
   localparam logic [5:0] HALF_4M  = 6'(CLK_HZ / (2 * BITCLK_4M_HZ));
   localparam logic [5:0] HALF_8M  = 6'(CLK_HZ / (2 * BITCLK_8M_HZ));
   localparam logic [2:0] ADJ_MAX  = 3'h4;
   localparam logic [4:0] SHAPE_HALVES = 5'h10;
   localparam logic [1:0] SYNC_MISS_LIMIT = 2'h2;

   typedef enum logic [1:0] {ROUTE_OFF, ROUTE_LOOP, ROUTE_PIN_A, ROUTE_PIN_B} route_t;

   typedef struct packed {
      route_t     code;
      logic [4:0] chan;
      logic       dir;
   } routeEntry_t;

   typedef struct packed {
      logic       valid;
      logic [4:0] chan;
      logic [7:0] data;
   } rxWord_t;
endpackage

//--- bench/pcm_peer_model.sv
// far-side bus peer that resolves the two serial data pins
`timescale 1ns/10ps
`default_nettype none
module pcm_peer_model (
   input  wire logic pinOneOut,
   input  wire logic pinOneOeN,
   input  wire logic pinTwoOut,
   input  wire logic pinTwoOeN,
   output logic      pinOneIn,
   output logic      pinTwoIn
);
   // a silent block leaves the peer's own idle pattern: ones on pin one, zeros on pin two
   assign pinOneIn = (pinOneOeN === 1'b0) ? pinOneOut : 1'b1;
   assign pinTwoIn = (pinTwoOeN === 1'b0) ? pinTwoOut : 1'b0;
endmodule
`default_nettype wire

//--- bench/pcm_bus_timing_routing_tb_top.sv
// self-checking bench of the pcm bus timing and routing block
`timescale 1ns/10ps
`default_nettype none
module pcm_bus_timing_routing_tb_top;
   import pcm_timing_pkg::*;
   typedef struct packed {logic [7:0] md; logic s; logic l; logic e;} row_t;
   const row_t rows[4] = '{'{8'h08,1,0,1}, '{8'h08,0,1,0}, '{8'h00,1,0,0}, '{8'h00,0,1,1}};
   logic mclk, nrst, read, write, waitrequest, syncIn, lineSync, syncOut, pllClockOut, frameSyncPulse;
   logic shapePulseA, shapePulseB, pinOneIn, pinOneOut, pinOneOeN, pinTwoIn, pinTwoOut, pinTwoOeN, txActive;
   logic [7:0]  address, txByte, slotSelectPin, q, selMask;
   logic [31:0] writedata, readdata;
   logic [3:0]  byteenable;
   logic [6:0]  slotCount, maxSlot;
   logic [4:0]  txChannel, txCh;
   rxWord_t     rxWord;
   logic [7:0]  rxData [32];
   logic        rxSeen [32];
   logic        drvOne, drvTwo, shA, shB, sPrev, cPrev, fsPrev;
   int          errors, n_tests, i, k, cnt, pc, fsCnt;

   pcm_bus_timing_routing dut (.mclk(mclk), .nrst(nrst), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .syncIn(syncIn), .lineSync(lineSync), .syncOut(syncOut), .pllClockOut(pllClockOut),
      .frameSyncPulse(frameSyncPulse), .slotSelectPin(slotSelectPin), .shapePulseA(shapePulseA),
      .shapePulseB(shapePulseB), .slotCountOut(slotCount), .pinOneIn(pinOneIn), .pinOneOut(pinOneOut),
      .pinOneOeN(pinOneOeN), .pinTwoIn(pinTwoIn), .pinTwoOut(pinTwoOut), .pinTwoOeN(pinTwoOeN),
      .txChannel(txChannel), .txActive(txActive), .txByte(txByte), .rxWord(rxWord));
   pcm_peer_model peer (.pinOneOut(pinOneOut), .pinOneOeN(pinOneOeN), .pinTwoOut(pinTwoOut),
      .pinTwoOeN(pinTwoOeN), .pinOneIn(pinOneIn), .pinTwoIn(pinTwoIn));

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      if (rxWord.valid === 1'b1) begin
         rxSeen[rxWord.chan] <= 1'b1;
         rxData[rxWord.chan] <= rxWord.data;
      end
      if (pinOneOeN === 1'b0) drvOne <= 1'b1;
      if (pinTwoOeN === 1'b0) drvTwo <= 1'b1;
      if (shapePulseA === 1'b1) shA <= 1'b1;
      if (shapePulseB === 1'b1) shB <= 1'b1;
      if (slotCount > maxSlot) maxSlot <= slotCount;
      if (txActive === 1'b1) txCh <= txChannel;
      if (slotSelectPin !== 8'h00) selMask <= selMask | slotSelectPin;
      fsPrev <= frameSyncPulse;
      if (frameSyncPulse === 1'b1 && fsPrev === 1'b0) fsCnt <= fsCnt + 1;
   end

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic results();
      if (errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // avalon master: holds the request until waitrequest is seen low, then releases after that edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge mclk);
      address <= a;
      write <= wr;
      read <= ~wr;
      writedata <= {24'h0, d};
      for (n = 0; n < 16; n++) begin
         @(posedge mclk);
         if (waitrequest === 1'b0) break;
      end
      if (n == 16) chk("bus answer", 8'h1, 8'h0);
      q = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic mr(input logic [3:0] idx, input logic [7:0] d);
      bus(1'b1, IDX_MODE_ZERO, {idx, 4'h0});
      bus(1'b1, IDX_MULTI, d);
   endtask

   // slot and direction are always selected before the routing entry is written
   task automatic route(input logic [6:0] slot, input logic dir, input route_t c, input logic [4:0] ch);
      bus(1'b1, IDX_SLOT_SEL, {slot, dir});
      bus(1'b1, IDX_ROUTING, routeEntry_t'{c, ch, dir});
   endtask

   task automatic clr();
      @(posedge mclk);
      rxSeen <= '{default: 1'b0};
      {drvOne, drvTwo, shA, shB, maxSlot, txCh, selMask} <= '0;
   endtask

   initial begin
      {nrst, read, write, syncIn, lineSync, address, writedata} = '0;
      byteenable = 4'hf;
      txByte = 8'ha5;
      {errors, n_tests, fsCnt} = '0;
      rxSeen = '{default: 1'b0};
      {drvOne, drvTwo, shA, shB, maxSlot, txCh, selMask, fsPrev} = '0;
      repeat (3) @(posedge mclk);
      nrst <= 1'b1;
      @(negedge mclk);
      chk("count out in style 0", 8'h0, {1'b0, slotCount});
      chk("pin one enable", 8'h1, {7'h0, pinOneOeN});
      mr(MR_MODE_ONE, 8'h00);
      for (i = 0; i < 4; i++) begin
         mr(MR_MODE_TWO, rows[i].md);
         syncIn <= rows[i].s;
         lineSync <= rows[i].l;
         repeat (3) @(posedge mclk);
         @(negedge mclk);
         chk("sync out", {7'h0, rows[i].e}, {7'h0, syncOut});
      end
      syncIn <= 1'b0;
      lineSync <= 1'b0;
      mr(MR_MODE_TWO, 8'h02);
      // half bit clock of 30 cycles: one sync period is 480 cycles
      cnt = 0;
      pc = 0;
      for (k = 0; k < 4800; k++) begin
         @(negedge mclk);
         if (syncOut === 1'b1 && sPrev === 1'b0) cnt++;
         if (pllClockOut === 1'b1 && cPrev === 1'b0) pc++;
         sPrev = syncOut;
         cPrev = pllClockOut;
      end
      chk("sync divided clock", 8'h1, {7'h0, cnt >= 9 && cnt <= 11});
      chk("bit clock", 8'h1, {7'h0, pc >= 79 && pc <= 81});
      mr(MR_MODE_TWO, 8'h00);
      for (i = 0; i < 3; i++) route(i[6:0], 1'b0, ROUTE_OFF, 5'd0);
      route(7'd1, 1'b0, ROUTE_PIN_B, 5'd9);
      route(7'd0, 1'b1, ROUTE_PIN_B, 5'd3);
      route(7'd1, 1'b1, ROUTE_PIN_A, 5'd4);
      route(7'd2, 1'b1, ROUTE_OFF, 5'd5);
      mr(4'h0, 8'h00);
      mr(MR_SHA_LOW, 8'h01);
      clr();
      for (k = 0; k < 40000; k++) begin
         @(posedge mclk);
         if (rxSeen[3] && rxSeen[4]) break;
      end
      if (k == 40000) chk("rx wait", 8'h1, 8'h0);
      repeat (2000) @(posedge mclk);
      chk("rx from idle pin one", 8'hff, rxData[3]);
      chk("rx from driven pin two", 8'ha5, rxData[4]);
      chk("tx channel", 8'h09, {3'h0, txCh});
      chk("select pins", 8'h01, selMask);
      chk("rx ignored", 8'h0, {7'h0, rxSeen[5]});
      chk("pin two driven", 8'h1, {7'h0, drvTwo});
      chk("pin one silent", 8'h0, {7'h0, drvOne});
      route(7'd0, 1'b0, ROUTE_PIN_A, 5'd7);
      mr(MR_SHA_HIGH, 8'h80);
      mr(MR_MODE_ONE, 8'h41);
      mr(MR_MODE_TWO, 8'hc0);
      clr();
      for (k = 0; k < 40000; k++) begin
         @(posedge mclk);
         if (rxSeen[3] && maxSlot === SLOTS_2M) break;
      end
      if (k == 40000) chk("loop wait", 8'h1, 8'h0);
      chk("looped byte", 8'ha5, rxData[3]);
      chk("last slot count", {1'b0, SLOTS_2M}, {1'b0, maxSlot});
      chk("shape a tail level", 8'h1, {7'h0, shA});
      chk("shape b stays low", 8'h0, {7'h0, shB});
      bus(1'b0, IDX_FCNT_LOW, 8'h00);
      chk("frame count low", 8'h1, {7'h0, q >= 8'h01 && q <= 8'h06});
      chk("frame pulses", q + 8'h01, fsCnt[7:0]);
      bus(1'b0, IDX_FCNT_HIGH, 8'h00);
      chk("frame count high", 8'h00, q);
      bus(1'b0, 8'h20, 8'h00);
      chk("unmapped read", 8'h00, q);
      bus(1'b0, IDX_MULTI, 8'h00);
      chk("write-only read", 8'h00, q);
      results();
   end
endmodule
`default_nettype wire
